// >>> rtl/dsc_ctrl.sv
// dual-slope converter controller: sequencer, serial port, axi4-lite registers
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

// Operation
// R1: step the analog processor through its four phases in order.
// R2: integrate drives A high, B low; comparator low there means negative.
// R3: level mode ends deintegration as soon as comparator reads low.
// R4: edge mode samples comparator on entry; low ends at once, else wait edge.
// R5: hold 18-bit result (overrange, sign, 16 bits) until read or replaced.
// R6: output shift register is not refreshed while result is being read.
// R7: host shifts any number of result bits at any rate, anytime.
// R8: every phase length counts only the controller's own clock.
// R9: phase timer is a fixed divide-by-256 stage cascaded with divide-by-N.
// R10: host rewrites the 8-bit multiplier serially to change conversion rate.
// R11: serial result output is released while chip select is inactive.
// R12: overrange bit serves as the top bit of a 17-bit magnitude.
// R13: sequencing tick is the system clock divided by four.
// R14: inactive chip select forces the offset-null phase, A low, B high.
// R15: load fall clears multiplier, captures input to MSB, MSB first, phases null.
// R16: read low shows overrange; falling strobes then give sign and data MSB first.
module dsc_ctrl #(
  parameter int DIV = dsc_pkg::TICK_DIV
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  input  wire logic [3:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [3:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        CE_N_I,
  input  wire logic        LOAD_N_I,
  input  wire logic        READ_N_I,
  input  wire logic        SHIFT_STROBE_I,
  input  wire logic        DIN_I,
  output logic             DOUT_O,
  output logic             DOUT_OE_O,
  input  wire logic        COMP_I,
  output logic             PHASE_A_O,
  output logic             PHASE_B_O
);
  import dsc_pkg::*;

  // ==========================================================
  // declarations
  logic        core_tick;
  logic [1:0]  ctrl;
  dsc_phase_t  phase;
  dsc_sel_t    sel;
  logic [7:0]  lo_cnt;
  logic [7:0]  hi_cnt;
  logic [7:0]  mult_active;
  logic [7:0]  mult_shift;
  logic [2:0]  mult_ptr;
  logic        mult_more;
  logic [15:0] res_cnt;
  logic        sign;
  logic        deint_first;
  logic        comp_prev;
  logic [7:0]  iz_cnt;
  dsc_result_t conv;
  dsc_result_t held;
  logic        pending;
  logic        result_new;
  logic [17:0] shreg;
  logic        strobe_q;
  logic        load_q;
  logic        strobe_rise;
  logic        strobe_fall;
  logic        load_fall;
  logic        load_rise;
  logic        hold;
  logic        timer_done;
  logic        deint_end;
  logic        conv_done;
  logic        aw_full;
  logic        w_full;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        rd_go;
  logic        rd_result;

  // ==========================================================
  // core tick: all phase timing hangs off this enable only
  dsc_tick_div #(
    .DIV (DIV)
  ) u_tick (
    .clk_i  (CLK_SYS_I),
    .rst_i  (RST_I),
    .tick_o (core_tick)   // R13 R8
  );

  // ==========================================================
  // pin edge detection (pins are taken as synchronous)
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      strobe_q <= 1'b0;
      load_q   <= 1'b1;
    end else begin
      strobe_q <= SHIFT_STROBE_I;
      load_q   <= LOAD_N_I;
    end
  end

  assign strobe_rise = SHIFT_STROBE_I & ~strobe_q;
  assign strobe_fall = ~SHIFT_STROBE_I & strobe_q;
  assign load_fall   = ~LOAD_N_I & load_q;
  assign load_rise   = LOAD_N_I & ~load_q;

  // deselect, a load in progress or software stop park the processor
  assign hold = CE_N_I | ~LOAD_N_I | ~ctrl[CTRL_RUN_BIT];   // R14 R15

  // ==========================================================
  // phase timer: low byte always /256, high byte up from multiplier
  // to wrap, so N is the two's complement of the loaded value
  assign timer_done = (lo_cnt == 8'hFF) && (hi_cnt == 8'hFF);   // R9

  // level mode stops on a low comparator; edge mode on entry-low or fall
  always_comb begin
    deint_end = 1'b0;
    if (res_cnt == 16'hFFFF) begin
      deint_end = 1'b1;
    end else if (!ctrl[CTRL_EDGE_BIT]) begin
      deint_end = ~COMP_I;   // R3
    end else if (deint_first) begin
      deint_end = ~COMP_I;   // R4
    end else begin
      deint_end = comp_prev & ~COMP_I;   // R4
    end
  end

  assign conv_done = core_tick && !hold && (phase == PH_DEINT) && deint_end;

  // ==========================================================
  // phase sequencer
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      phase <= PH_NULL;
    end else if (hold) begin
      phase <= PH_NULL;   // R14
    end else if (core_tick) begin
      unique case (phase)
        PH_NULL:  if (timer_done) phase <= PH_INT;   // R1
        PH_INT:   if (timer_done) phase <= PH_DEINT;
        PH_DEINT: if (deint_end) phase <= PH_IZ;
        PH_IZ:    if (COMP_I || iz_cnt == IZ_MAX_TICKS) phase <= PH_NULL;
      endcase
    end
  end

  // timer restarts whenever a timed phase ends or the sequence is parked
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      lo_cnt <= 8'h00;
      hi_cnt <= MULT_RESET;
    end else if (hold || load_rise || (core_tick && timer_done) ||
                 (phase == PH_DEINT) || (phase == PH_IZ)) begin
      lo_cnt <= 8'h00;
      hi_cnt <= load_rise ? mult_shift : mult_active;   // R10
    end else if (core_tick) begin
      lo_cnt <= lo_cnt + 8'h01;   // R9
      if (lo_cnt == 8'hFF) begin
        hi_cnt <= hi_cnt + 8'h01;
      end
    end
  end

  // deintegration count, sign capture and entry flag
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      res_cnt     <= 16'h0000;
      sign        <= 1'b0;
      deint_first <= 1'b0;
      comp_prev   <= 1'b0;
    end else if (core_tick) begin
      comp_prev <= COMP_I;
      if (phase == PH_INT && timer_done) begin
        sign        <= COMP_I;   // R2
        res_cnt     <= 16'h0000;
        deint_first <= 1'b1;
      end else if (phase == PH_DEINT) begin
        res_cnt     <= res_cnt + 16'h0001;
        deint_first <= 1'b0;
      end
    end
  end

  // integrator-zero phase may end early once the comparator is high again
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      iz_cnt <= 8'h00;
    end else if (phase != PH_IZ) begin
      iz_cnt <= 8'h00;
    end else if (core_tick) begin
      iz_cnt <= iz_cnt + 8'h01;
    end
  end

  assign sel       = sel_of(phase);
  assign PHASE_A_O = sel.a;   // R1 R2
  assign PHASE_B_O = sel.b;

  // ==========================================================
  // result path: conv fills on each finished conversion, held only when nobody reads
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      conv <= '0;
    end else if (conv_done) begin
      conv.over <= (res_cnt == 16'hFFFF);   // R12
      conv.sign <= sign;
      conv.mag  <= (res_cnt == 16'hFFFF) ? 16'h0000 : res_cnt;   // R5
    end
  end

  // a conversion that lands during a read waits here, not in held
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pending <= 1'b0;
      held    <= '0;
    end else if (conv_done) begin
      pending <= 1'b1;
    end else if (pending && READ_N_I) begin
      held    <= conv;   // R6
      pending <= 1'b0;
    end
  end

  // shift register tracks held while idle, shifts only on strobe falls during a read
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      shreg <= '0;
    end else if (READ_N_I) begin
      shreg <= held;   // R16
    end else if (strobe_fall) begin
      shreg <= {shreg[16:0], 1'b0};   // R16 R7
    end
  end

  assign DOUT_O    = shreg[17];
  assign DOUT_OE_O = ~CE_N_I;   // R11

  // ==========================================================
  // multiplier load port: MSB sampled on load fall, the rest on rising strobe, committed on load rise
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      mult_shift <= 8'h00;
      mult_ptr   <= 3'h0;
      mult_more  <= 1'b0;
    end else if (load_fall) begin
      mult_shift <= {DIN_I, 7'h00};   // R15
      mult_ptr   <= 3'h6;
      mult_more  <= 1'b1;
    end else if (!LOAD_N_I && strobe_rise && mult_more) begin
      mult_shift[mult_ptr] <= DIN_I;   // R15
      mult_ptr             <= mult_ptr - 3'h1;
      mult_more            <= (mult_ptr != 3'h0);
    end
  end

  // serial commit wins over a same-cycle bus write
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      mult_active <= MULT_RESET;
    end else if (load_rise) begin
      mult_active <= mult_shift;   // R10
    end else if (wr_go && aw_addr == OFF_MULT && w_strb[0]) begin
      mult_active <= w_data[7:0];
    end
  end

  // ==========================================================
  // axi4-lite write channel: address and data taken in either order
  assign S_AXI_AWREADY_O = ~aw_full & ~S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = ~w_full & ~S_AXI_BVALID_O;
  assign wr_go           = aw_full & w_full & ~S_AXI_BVALID_O;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      aw_full <= 1'b0;
      aw_addr <= 4'h0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_full <= 1'b1;
      aw_addr <= {S_AXI_AWADDR_I[3:2], 2'b00};
    end else if (wr_go) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_full <= 1'b1;
      w_data <= S_AXI_WDATA_I;
      w_strb <= S_AXI_WSTRB_I;
    end else if (wr_go) begin
      w_full <= 1'b0;
    end
  end

  // response; read-only and unmapped words answer with an error
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= (aw_addr == OFF_CTRL || aw_addr == OFF_MULT) ?
                        RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl <= CTRL_RESET;
    end else if (wr_go && aw_addr == OFF_CTRL && w_strb[0]) begin
      ctrl <= w_data[1:0];
    end
  end

  // ==========================================================
  // axi4-lite read channel, one-cycle answer
  assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;
  assign rd_go           = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  assign rd_result       = rd_go && ({S_AXI_ARADDR_I[3:2], 2'b00} == OFF_RESULT);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0000_0000;
      S_AXI_RRESP_O  <= RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O  <= RESP_OKAY;
      S_AXI_RDATA_O  <= 32'h0000_0000;
      unique case ({S_AXI_ARADDR_I[3:2], 2'b00})
        OFF_CTRL:   S_AXI_RDATA_O[1:0]  <= ctrl;
        OFF_STATUS: S_AXI_RDATA_O[4:0]  <= {~LOAD_N_I, ~READ_N_I, result_new, phase};
        OFF_RESULT: S_AXI_RDATA_O[17:0] <= held;   // R12
        OFF_MULT:   S_AXI_RDATA_O[7:0]  <= mult_active;
        default:    S_AXI_RRESP_O       <= RESP_SLVERR;
      endcase
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // new-result flag: a conversion in the clearing cycle keeps it set
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      result_new <= 1'b0;
    end else if (conv_done) begin
      result_new <= 1'b1;
    end else if (rd_result) begin
      result_new <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  tick_period_a: assert property (core_tick |=> !core_tick [*3] ##1 core_tick) // R13
    else $error("core tick not every fourth cycle");

  hold_null_a: assert property (hold |=> (!PHASE_A_O && PHASE_B_O)) // R14
    else $error("phases not parked at offset null");

  int_levels_a: assert property ((phase == PH_INT) |-> (PHASE_A_O && !PHASE_B_O)) // R2
    else $error("integrate levels wrong");

  phase_order_a: assert property ($changed(phase) |-> (phase == PH_NULL) ||
      (phase == PH_INT && $past(phase) == PH_NULL) ||
      (phase == PH_DEINT && $past(phase) == PH_INT) ||
      (phase == PH_IZ && $past(phase) == PH_DEINT)) // R1
    else $error("illegal phase step");

  timer_exit_a: assert property ((core_tick && !hold && phase == PH_NULL &&
      lo_cnt == 8'hFF && hi_cnt == 8'hFF) |=> phase == PH_INT) // R9
    else $error("timer wrap did not end offset null");

  level_stop_a: assert property ((core_tick && !hold && phase == PH_DEINT &&
      !ctrl[CTRL_EDGE_BIT] && !COMP_I) |=> phase == PH_IZ) // R3
    else $error("low comparator did not end deintegration");

  edge_entry_a: assert property ((core_tick && !hold && phase == PH_DEINT &&
      deint_first && !COMP_I) |=> phase == PH_IZ) // R4
    else $error("low entry did not end deintegration");

  read_freeze_a: assert property ((!READ_N_I && !strobe_fall) |=> shreg == $past(shreg)) // R6
    else $error("shift register refreshed during read");

  shift_step_a: assert property ((!READ_N_I && strobe_fall) |=>
      shreg == {$past(shreg[16:0]), 1'b0}) // R16
    else $error("strobe fall did not advance result");

  release_a: assert property (CE_N_I |-> !DOUT_OE_O) // R11
    else $error("output driven while deselected");

  load_clear_a: assert property (load_fall |=> mult_shift == {$past(DIN_I), 7'h00}) // R15
    else $error("load fall did not clear and capture");

  mult_commit_a: assert property (load_rise |=> mult_active == $past(mult_shift)) // R10
    else $error("multiplier not committed");

  conv_cover: cover property (conv_done ##[1:40] (phase == PH_NULL));
  read_cover: cover property (!READ_N_I && conv_done);
  load_cover: cover property (load_fall ##[1:200] load_rise);
  over_cover: cover property (conv_done && res_cnt == 16'hFFFF);

endmodule

// >>> rtl/dsc_pkg.sv
// shared constants and types of the dual-slope converter controller
package dsc_pkg;

  // ==========================================================
  // register map (byte offsets, one aligned word each)
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_RESULT = 4'h8;
  localparam logic [3:0] OFF_MULT   = 4'hC;

  // ==========================================================
  // field positions
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_EDGE_BIT = 1;
  localparam int ST_PHASE_LSB  = 0;
  localparam int ST_NEW_BIT    = 2;
  localparam int ST_READ_BIT   = 3;
  localparam int ST_LOAD_BIT   = 4;

  // ==========================================================
  // reset values, timing counts and response codes
  localparam logic [1:0] CTRL_RESET   = 2'h1;
  localparam logic [7:0] MULT_RESET   = 8'h80;
  localparam int         TICK_DIV     = 4;
  localparam logic [7:0] IZ_MAX_TICKS = 8'hFF;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ==========================================================
  // conversion phases, gray coded along the cycle
  typedef enum logic [1:0] {
    PH_NULL  = 2'b00,
    PH_INT   = 2'b01,
    PH_DEINT = 2'b11,
    PH_IZ    = 2'b10
  } dsc_phase_t;

  typedef struct packed {
    logic a;
    logic b;
  } dsc_sel_t;

  typedef struct packed {
    logic        over;
    logic        sign;
    logic [15:0] mag;
  } dsc_result_t;

  // phase-select levels driven to the analog processor
  function automatic dsc_sel_t sel_of(input dsc_phase_t ph);
    dsc_sel_t s;
    s.a = (ph == PH_INT) || (ph == PH_DEINT);
    s.b = (ph == PH_NULL) || (ph == PH_DEINT);
    return s;
  endfunction

endpackage

// >>> rtl/dsc_tick_div.sv
// clock prescaler making the one-cycle core_tick enable
`timescale 1ns/1ps

module dsc_tick_div #(
  parameter int DIV = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);

  localparam int W = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  localparam logic [W-1:0] PRE  = W'(DIV - 2);

  logic [W-1:0] cnt;

  // free-running divider, wraps after DIV cycles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + W'(1);
    end
  end

  // tick registered one cycle ahead so it leaves a flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt == PRE);
    end
  end

endmodule

// >>> verif/dsc_analog_model.sv
// behavioural analog processor: integrator and comparator steered by the phase pins
`timescale 1ns/1ps

module dsc_analog_model #(
  parameter int REF = 16
) (
  input  wire logic               clk_i,
  input  wire logic               a_i,
  input  wire logic               b_i,
  input  wire logic signed [31:0] vin_i,
  output logic                    comp_o
);
  int   acc = 0;
  logic wob = 1'b0;

  // ==========================================================
  // integrator: ramps with the input, returns to zero on the reference
  always @(posedge clk_i) begin
    wob <= ~wob;
    case ({a_i, b_i})
      2'b10: acc <= acc + vin_i;
      2'b11: acc <= (acc > REF) ? acc - REF : ((acc < -REF) ? acc + REF : 0);
      default: acc <= 0;
    endcase
  end

  // comparator is undefined outside the two slopes, so it wobbles there
  always_comb begin
    case ({a_i, b_i})
      2'b10: comp_o = (acc > 0);
      2'b11: comp_o = (acc != 0);
      default: comp_o = wob;
    endcase
  end
endmodule

// >>> verif/tb_dual_slope_adc_serial_controller.sv
// self-checking bench: axi4-lite registers, serial host link, analog model
`timescale 1ns/1ps

module tb_dual_slope_adc_serial_controller;
  import dsc_pkg::*;
  logic               clk = 1'b0, rst = 1'b1;
  logic [3:0]         awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0]        wdata = 32'h0, rdata;
  logic               awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic               ce_n = 1'b0, load_n = 1'b1, read_n = 1'b1, strobe = 1'b0, din = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid, dout, dout_oe, comp, pa, pb;
  logic [1:0]         bresp, rresp, prev = 2'b01;
  logic signed [31:0] vin = 32'sh0;
  int                 n_fail = 0, checked = 0, cyc = 0, int_len = 0, exp_int = 0;

  dsc_ctrl uut (
    .CLK_SYS_I(clk), .RST_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .CE_N_I(ce_n), .LOAD_N_I(load_n), .READ_N_I(read_n), .SHIFT_STROBE_I(strobe),
    .DIN_I(din), .DOUT_O(dout), .DOUT_OE_O(dout_oe), .COMP_I(comp),
    .PHASE_A_O(pa), .PHASE_B_O(pb)
  );

  dsc_analog_model #(.REF(16)) ana (
    .clk_i(clk), .a_i(pa), .b_i(pb), .vin_i(vin), .comp_o(comp)
  );

  // 125 MHz system clock
  always #4 clk = ~clk;

  // ==========================================================
  // verdict and comparison
  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ceiling well above the roughly 20k cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      test_done();
    end
  end

  function automatic logic [1:0] nxt(input logic [1:0] p);
    case (p)
      2'b01: return 2'b10;
      2'b10: return 2'b11;
      2'b11: return 2'b00;
      default: return 2'b01;
    endcase
  endfunction

  // phase pins: order of phases, integrate length in clocks
  always @(posedge clk) begin
    if (!rst && {pa, pb} !== prev) begin
      if ({pa, pb} !== 2'b01) check("phase order", {pa, pb}, nxt(prev));
      if (prev == 2'b10 && {pa, pb} == 2'b11) check("int len", int_len, exp_int);
      int_len <= 1;
    end else begin
      int_len <= int_len + 1;
    end
    prev <= {pa, pb};
  end

  // ==========================================================
  // axi4-lite master: payload held until each channel is taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    logic at, wt, bt;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    bt = 1'b0;
    while (!bt) begin
      @(negedge clk);
      at = awv & awready;
      wt = wv & wready;
      bt = bvalid;
      r = bresp;
      @(posedge clk);
      if (at) awv <= 1'b0;
      if (wt) wv <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    logic at, rt;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    rt = 1'b0;
    while (!rt) begin
      @(negedge clk);
      at = arv & arready;
      rt = rvalid;
      d = rdata;
      @(posedge clk);
      if (at) arv <= 1'b0;
    end
    rready <= 1'b0;
    check("rresp", rresp, RESP_OKAY);
  endtask

  // ==========================================================
  // serial host link: strobe high for three clocks, low for five
  task automatic stb(input logic d);
    @(posedge clk);
    din <= d;
    @(posedge clk);
    strobe <= 1'b1;
    repeat (3) @(posedge clk);
    strobe <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic ser_load(input logic [7:0] m);
    @(posedge clk);
    din <= m[7];
    @(posedge clk);
    load_n <= 1'b0;
    @(negedge clk);
    check("load parks", {pa, pb}, 2'b01);
    for (int i = 6; i >= 0; i--) stb(m[i]);
    load_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic ser_read(output logic [17:0] v);
    @(posedge clk);
    read_n <= 1'b0;
    repeat (3) @(negedge clk);
    v[17] = dout;
    check("dout oe", dout_oe, 1'b1);
    for (int i = 16; i >= 0; i--) begin
      stb(1'b0);
      @(negedge clk);
      v[i] = dout;
    end
    @(posedge clk);
    read_n <= 1'b1;
  endtask

  // poll status until the masked field matches
  task automatic wait_st(input logic [4:0] m, input logic [4:0] val);
    logic [31:0] d;
    do axr(OFF_STATUS, d); while ((d[4:0] & m) !== val);
  endtask

  function automatic logic near(input logic [15:0] x, input int m);
    return (int'(x) >= m - 2) && (int'(x) <= m + 2);
  endfunction

  // one conversion: result fields, then new flag cleared by the read
  task automatic conv(input logic s, input int m);
    logic [31:0] d;
    wait_st(5'h04, 5'h04);
    axr(OFF_RESULT, d);
    check("over", d[17], 1'b0);
    check("sign", d[16], s);
    check("mag", near(d[15:0], m), 1'b1);
    axr(OFF_STATUS, d);
    check("new clr", d[ST_NEW_BIT], 1'b0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [17:0] v;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    axr(OFF_MULT, d);
    check("mult rst", d, {24'h0, MULT_RESET});
    axw(OFF_STATUS, 32'h1F, 4'hF, r);
    check("status wr", r, RESP_SLVERR);
    axw(OFF_RESULT, 32'h0, 4'hF, r);
    check("result wr", r, RESP_SLVERR);
    axw(OFF_MULT, 32'hFF, 4'h0, r);
    axr(OFF_MULT, d);
    check("mult nostrb", d, 32'h80);
    exp_int = 2048;
    vin <= 32'sh14;
    ser_load(8'hFE);
    axr(OFF_MULT, d);
    check("mult serial", d, 32'hFE);
    wait_st(5'h03, {3'h0, PH_INT});
    @(negedge clk);
    check("int pins", {pa, pb}, 2'b10);
    conv(1'b1, 640);
    @(posedge clk);
    ce_n <= 1'b1;
    repeat (2) @(negedge clk);
    check("released", dout_oe, 1'b0);
    check("parked", {pa, pb}, 2'b01);
    axw(OFF_MULT, 32'hFF, 4'h1, r);
    check("mult wr", r, RESP_OKAY);
    exp_int = 1024;
    ce_n <= 1'b0;
    conv(1'b1, 320);
    // a conversion completes while the result is being read
    vin <= -32'sh0A;
    read_n <= 1'b0;
    wait_st(5'h03, {3'h0, PH_INT});
    wait_st(5'h03, {3'h0, PH_IZ});
    axr(OFF_STATUS, d);
    check("new held", d[ST_NEW_BIT], 1'b1);
    check("read act", d[ST_READ_BIT], 1'b1);
    ser_read(v);
    check("ser over", v[17], 1'b0);
    check("ser sign", v[16], 1'b1);
    check("ser mag", near(v[15:0], 320), 1'b1);
    conv(1'b0, 160);
    vin <= 32'sh0;
    conv(1'b0, 0);
    axw(OFF_CTRL, 32'h3, 4'h1, r);
    conv(1'b0, 0);
    vin <= 32'sh14;
    conv(1'b1, 320);
    test_done();
  end
endmodule
